// [bench/modbus_pdu_register_server_tb_top.sv]
// testbench top for the pdu register server
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", nm, ex, got); end end

module modbus_pdu_register_server_tb_top;
  typedef logic [7:0] mpr_bq_t[$];
  logic        clk, rst_b, req_valid, req_last, req_ready, rsp_valid, rsp_last, rsp_ready;
  logic        in_reg_en, word_en, srv_fault, stall_on;
  logic [7:0]  req_data, rsp_data, mw_rd_addr;
  logic [15:0] in_reg_addr, in_reg_data, mw_rd_data;
  logic [15:0] mem [256];
  logic [8:0]  exp_q[$];
  logic [8:0]  e;
  int          err_total, total_checks;
  bit          tmo;

  mpr_server DUT (.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req_data(req_data),
    .req_last(req_last), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_last(rsp_last), .rsp_ready(rsp_ready), .in_reg_addr(in_reg_addr),
    .in_reg_data(in_reg_data), .in_reg_en(in_reg_en), .word_en(word_en),
    .srv_fault(srv_fault), .mw_rd_addr(mw_rd_addr), .mw_rd_data(mw_rd_data));
  mpr_client u_cli (.clk(clk), .req_ready(req_ready), .stall_on(stall_on),
    .req_valid(req_valid), .req_data(req_data), .req_last(req_last), .rsp_ready(rsp_ready));

  // input register source: distinct value per index
  function automatic logic [15:0] ir(logic [15:0] a);
    return {a[7:0] ^ 8'hA5, a[7:0]};
  endfunction
  assign in_reg_data = ir(in_reg_addr);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------
  // response monitor
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst_b && rsp_valid && rsp_ready) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("[ERR] rsp_extra exp none got %h", rsp_data);
      end else begin
        e = exp_q.pop_front();
        `CHK("rsp", e, {rsp_last, rsp_data})
      end
    end
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // request helpers
  // ----------------------------------------
  function automatic mpr_bq_t h5(logic [7:0] f, logic [15:0] a, logic [15:0] q);
    return '{f, a[15:8], a[7:0], q[15:8], q[7:0]};
  endfunction
  function automatic mpr_bq_t er(logic [7:0] f, logic [7:0] c);
    return '{f + 8'h80, c};
  endfunction

  // note expectations, send, then wait for drain
  task automatic xfer(input mpr_bq_t rq, input mpr_bq_t ex);
    int w;
    foreach (ex[i]) exp_q.push_back({i == ex.size() - 1, ex[i]});
    u_cli.send(rq, tmo);
    w = 0;
    while ((exp_q.size() != 0 || !req_ready) && w < 2000) begin
      @(negedge clk);
      w++;
    end
    if (tmo || w == 2000) begin
      err_total++;
      $display("[ERR] wait exp done got hang");
      report_and_stop();
    end
  endtask

  task automatic rd_in(logic [15:0] a, logic [15:0] q);
    mpr_bq_t ex;
    logic [15:0] v;
    ex = '{8'h04, 8'(q * 2)};
    for (int k = 0; k < q; k++) begin
      v = ir(a + 16'(k));
      ex.push_back(v[15:8]);
      ex.push_back(v[7:0]);
    end
    xfer(h5(8'h04, a, q), ex);
  endtask

  task automatic wr1(logic [15:0] a, logic [15:0] v, logic [7:0] code);
    if (code == 8'h00) begin
      mem[a[7:0]] = v;
      xfer(h5(8'h06, a, v), h5(8'h06, a, v));
    end else xfer(h5(8'h06, a, v), er(8'h06, code));
  endtask

  task automatic wrn(logic [15:0] a, logic [15:0] q, logic [7:0] bc, logic [7:0] code);
    mpr_bq_t rq;
    logic [15:0] v;
    rq = h5(8'h10, a, q);
    rq.push_back(bc);
    for (int k = 0; k < bc / 2; k++) begin
      v = 16'(u_cli.rnd());
      rq.push_back(v[15:8]);
      rq.push_back(v[7:0]);
      if (code == 8'h00) mem[8'(a + 16'(k))] = v;
    end
    if (code == 8'h00) xfer(rq, h5(8'h10, a, q));
    else xfer(rq, er(8'h10, code));
  endtask

  // sweep the whole table against the shadow copy
  task automatic chk_all();
    for (int i = 0; i < 256; i++) begin
      @(negedge clk);
      mw_rd_addr = 8'(i);
      #1;
      `CHK("memory_word", mem[i], mw_rd_data)
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    in_reg_en = 1'b1;
    word_en = 1'b1;
    srv_fault = 1'b0;
    mw_rd_addr = 8'h00;
    stall_on = 1'b0;
    err_total = 0;
    total_checks = 0;
    foreach (mem[i]) mem[i] = 16'h0000;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    chk_all();
    rd_in(16'h0000, 16'h0001);
    rd_in(16'h0011, 16'h0002);
    stall_on = 1'b1;
    rd_in(16'h0003, 16'h007D);
    xfer(h5(8'h04, 16'h0000, 16'h0000), er(8'h04, 8'h03));
    xfer(h5(8'h04, 16'h0000, 16'h007E), er(8'h04, 8'h03));
    xfer(h5(8'h04, 16'h007F, 16'h0002), er(8'h04, 8'h02));
    in_reg_en = 1'b0;
    xfer(h5(8'h04, 16'h0000, 16'h0001), er(8'h04, 8'h02));
    in_reg_en = 1'b1;
    wr1(16'h0003, 16'(u_cli.rnd()), 8'h00);
    wr1(16'h0000, 16'hA55A, 8'h00);
    wr1(16'h0100, 16'h1111, 8'h02);
    word_en = 1'b0;
    wr1(16'h0005, 16'h2222, 8'h02);
    wrn(16'h0014, 16'h0002, 8'h04, 8'h02);
    word_en = 1'b1;
    srv_fault = 1'b1;
    wr1(16'h0006, 16'h3333, 8'h04);
    wrn(16'h0014, 16'h0002, 8'h04, 8'h04);
    srv_fault = 1'b0;
    wrn(16'h000A, 16'h0003, 8'h06, 8'h00);
    wrn(16'h0085, 16'h007B, 8'hF6, 8'h00);
    wrn(16'h0028, 16'h0000, 8'h00, 8'h03);
    wrn(16'h0028, 16'h007C, 8'hF8, 8'h03);
    wrn(16'h0028, 16'h0002, 8'h06, 8'h03);
    wrn(16'h00FF, 16'h0002, 8'h04, 8'h02);
    wrn(16'h012C, 16'h0000, 8'h00, 8'h02);
    chk_all();
    for (int f = 1; f < 3; f++) begin
      xfer(h5(8'(f), 16'h0000, 16'h0000), er(8'(f), 8'h03));
      xfer(h5(8'(f), 16'h0000, 16'h07D1), er(8'(f), 8'h03));
      xfer(h5(8'(f), 16'h0000, 16'h07D0), er(8'(f), 8'h02));
    end
    xfer(h5(8'h03, 16'h0000, 16'h0001), er(8'h03, 8'h01));
    xfer(h5(8'h05, 16'h0000, 16'h0001), er(8'h05, 8'h01));
    xfer(h5(8'hFF, 16'h0000, 16'h0001), er(8'hFF, 8'h01));
    report_and_stop();
  end
endmodule

// [bench/mpr_client.sv]
// client model: issues request pdus and sinks response bytes
`timescale 1ns/1ps

module mpr_client (
  input  wire logic       clk,
  input  wire logic       req_ready,
  input  wire logic       stall_on,
  output logic            req_valid,
  output logic [7:0]      req_data,
  output logic            req_last,
  output logic            rsp_ready
);
  integer seed = 32'hE2AE;

  // idle request lines at time zero
  initial begin
    req_valid = 1'b0;
    req_data  = 8'h00;
    req_last  = 1'b0;
    rsp_ready = 1'b1;
  end

  function automatic logic [31:0] rnd();
    rnd = $random(seed);
  endfunction

  // sink stalls about one cycle in three when asked
  always @(negedge clk) begin
    rsp_ready <= !stall_on || (rnd() % 3 != 0);
  end

  // one byte per edge with req_ready high; held until then
  task automatic send(input logic [7:0] rq[$], output bit tmo);
    int w;
    tmo = 1'b0;
    foreach (rq[i]) begin
      @(negedge clk);
      req_valid <= 1'b1;
      req_data  <= rq[i];
      req_last  <= (i == rq.size() - 1);
      w = 0;
      while (!req_ready && w < 1000) begin
        @(negedge clk);
        w++;
      end
      if (w == 1000) tmo = 1'b1;
      @(posedge clk);
    end
    @(negedge clk);
    req_valid <= 1'b0;
    req_last  <= 1'b0;
    req_data  <= ~req_data; // released data does not keep last value
  endtask
endmodule

// [core/mpr_consts.svh]
// constants for the pdu register server: function codes, exceptions, limits
`ifndef MPR_CONSTS_SVH
`define MPR_CONSTS_SVH

// ----------------------------------------
// function codes
// ----------------------------------------
`define MPR_FC_RD_COIL   8'h01
`define MPR_FC_RD_DIN    8'h02
`define MPR_FC_RD_IREG   8'h04
`define MPR_FC_WR_ONE    8'h06
`define MPR_FC_WR_MANY   8'h10
`define MPR_FC_ERR_FLAG  8'h80

// ----------------------------------------
// exception codes (none means success)
// ----------------------------------------
`define MPR_EXC_NONE     8'h00
`define MPR_EXC_FUNC     8'h01
`define MPR_EXC_ADDR     8'h02
`define MPR_EXC_VAL      8'h03
`define MPR_EXC_FAULT    8'h04

// ----------------------------------------
// quantity limits
// ----------------------------------------
`define MPR_QTY_MIN      16'h0001
`define MPR_BIT_QTY_MAX  16'h07D0
`define MPR_RD_QTY_MAX   16'h007D
`define MPR_WR_QTY_MAX   16'h007B
`define MPR_WR_MAX       123

// ----------------------------------------
// frame layout and lengths in bytes
// ----------------------------------------
`define MPR_HDR_LEN      9'h005
`define MPR_WRN_HDR_LEN  9'h006
`define MPR_RX_DATA_MAX  9'h0F6
`define MPR_ERR_LEN      9'h002
`define MPR_RD_HDR_LEN   9'h002
`define MPR_RX_CNT_MAX   9'h1FF

// ----------------------------------------
// table sizes
// ----------------------------------------
`define MPR_WORD_AW      8
`define MPR_WORD_NUM     17'h00100
`define MPR_INREG_NUM    17'h00080
`define MPR_WORD_RST     16'h0000

`endif

// [core/mpr_pkg.sv]
// types shared by the pdu register server
package mpr_pkg;
  typedef enum logic [3:0] {
    MPR_ST_RECV  = 4'h1,
    MPR_ST_CHECK = 4'h2,
    MPR_ST_WRITE = 4'h4,
    MPR_ST_SEND  = 4'h8
  } mpr_state_t;
endpackage

// [core/mpr_server.sv]
// pdu register server: request parsing, checks, table writes, responses
`timescale 1ns/1ps
`include "mpr_consts.svh"

module mpr_server (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        req_valid,
  input  wire logic [7:0]  req_data,
  input  wire logic        req_last,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic             rsp_last,
  input  wire logic        rsp_ready,
  output logic [15:0]      in_reg_addr,
  input  wire logic [15:0] in_reg_data,
  input  wire logic        in_reg_en,
  input  wire logic        word_en,
  input  wire logic        srv_fault,
  input  wire logic [7:0]  mw_rd_addr,
  output logic [15:0]      mw_rd_data
);

  mpr_pkg::mpr_state_t state_ff;
  mpr_pkg::mpr_state_t nxt_state;

  logic [7:0]  hdr_ff [0:5];
  logic [15:0] stage_ff [0:`MPR_WR_MAX-1];
  logic [8:0]  rx_cnt_ff;
  logic [7:0]  exc_ff;
  logic [7:0]  wr_idx_ff;
  logic [8:0]  tx_idx_ff;
  logic [8:0]  tx_len_ff;
  logic        rsp_valid_ff;
  logic        rsp_last_ff;
  logic [7:0]  rsp_data_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------
  // request fields
  // ----------------------------------------
  // big-endian fields, first byte of each pair is high
  wire [7:0]  fc         = hdr_ff[0];
  wire [15:0] start_addr = {hdr_ff[1], hdr_ff[2]};
  wire [15:0] qty        = {hdr_ff[3], hdr_ff[4]};
  wire [7:0]  byte_cnt   = hdr_ff[5];
  wire [16:0] range_end  = {1'b0, start_addr} + {1'b0, qty};

  wire st_recv  = state_ff == mpr_pkg::MPR_ST_RECV;
  wire st_check = state_ff == mpr_pkg::MPR_ST_CHECK;
  wire st_write = state_ff == mpr_pkg::MPR_ST_WRITE;
  wire st_send  = state_ff == mpr_pkg::MPR_ST_SEND;
  wire req_fire = st_recv && req_valid;

  // ----------------------------------------
  // validity checks
  // ----------------------------------------
  // whole range must be inside the map and enabled
  wire len_hdr     = rx_cnt_ff == `MPR_HDR_LEN;
  wire is_bit_rd   = fc == `MPR_FC_RD_COIL || fc == `MPR_FC_RD_DIN;
  wire bit_qty_ok  = qty >= `MPR_QTY_MIN && qty <= `MPR_BIT_QTY_MAX;
  wire rd_addr_ok  = in_reg_en && range_end <= `MPR_INREG_NUM;
  wire rd_qty_ok   = qty >= `MPR_QTY_MIN && qty <= `MPR_RD_QTY_MAX;
  wire wr1_addr_ok = word_en && {1'b0, start_addr} < `MPR_WORD_NUM;
  wire wrn_addr_ok = word_en && range_end <= `MPR_WORD_NUM;
  wire wrn_qty_ok  = qty >= `MPR_QTY_MIN && qty <= `MPR_WR_QTY_MAX;
  wire wrn_bc_ok   = {1'b0, byte_cnt} == {qty[7:0], 1'b0};
  wire wrn_len_ok  = rx_cnt_ff == `MPR_WRN_HDR_LEN + {1'b0, byte_cnt};

  // bit reads are only answered with error frames here
  wire [7:0] exc_bit = (!len_hdr || !bit_qty_ok) ? `MPR_EXC_VAL :
                       `MPR_EXC_ADDR;
  // reads never raise the server fault code
  wire [7:0] exc_rd  = !len_hdr    ? `MPR_EXC_VAL  :
                       !rd_addr_ok ? `MPR_EXC_ADDR :
                       !rd_qty_ok  ? `MPR_EXC_VAL  :
                       `MPR_EXC_NONE;
  wire [7:0] exc_wr1 = !len_hdr     ? `MPR_EXC_VAL   :
                       !wr1_addr_ok ? `MPR_EXC_ADDR  :
                       srv_fault    ? `MPR_EXC_FAULT :
                       `MPR_EXC_NONE;
  // header length first, then address, then count, then byte count
  wire [7:0] exc_wrn = (rx_cnt_ff < `MPR_WRN_HDR_LEN) ? `MPR_EXC_VAL :
                       !wrn_addr_ok ? `MPR_EXC_ADDR :
                       !wrn_qty_ok  ? `MPR_EXC_VAL  :
                       (!wrn_bc_ok || !wrn_len_ok) ? `MPR_EXC_VAL :
                       srv_fault    ? `MPR_EXC_FAULT :
                       `MPR_EXC_NONE;
  wire [7:0] chk_exc = is_bit_rd                ? exc_bit :
                       fc == `MPR_FC_RD_IREG    ? exc_rd  :
                       fc == `MPR_FC_WR_ONE     ? exc_wr1 :
                       fc == `MPR_FC_WR_MANY    ? exc_wrn :
                       `MPR_EXC_FUNC;
  wire is_write = fc == `MPR_FC_WR_ONE || fc == `MPR_FC_WR_MANY;
  wire [8:0] chk_len = (chk_exc != `MPR_EXC_NONE) ? `MPR_ERR_LEN :
                       (fc == `MPR_FC_RD_IREG) ? `MPR_RD_HDR_LEN + {qty[7:0], 1'b0} :
                       `MPR_HDR_LEN;

  // ----------------------------------------
  // receive path
  // ----------------------------------------
  // data bytes of a multi write are staged until checked
  wire [8:0] stage_off = rx_cnt_ff - `MPR_WRN_HDR_LEN;
  wire       stage_we  = req_fire && rx_cnt_ff >= `MPR_WRN_HDR_LEN
                         && stage_off < `MPR_RX_DATA_MAX;
  wire       hdr_we    = req_fire && rx_cnt_ff < `MPR_WRN_HDR_LEN;

  // header capture and byte counter
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 6; i++) begin
        hdr_ff[i] <= 8'h00;
      end
      rx_cnt_ff <= 9'h000;
    end else begin
      if (hdr_we) begin
        hdr_ff[rx_cnt_ff[2:0]] <= req_data;
      end
      if (req_fire && rx_cnt_ff != `MPR_RX_CNT_MAX) begin
        rx_cnt_ff <= rx_cnt_ff + 9'h001;
      end else if (st_send && nxt_state == mpr_pkg::MPR_ST_RECV) begin
        rx_cnt_ff <= 9'h000;
      end
    end
  end

  // staging of write values, high byte first
  always_ff @(posedge clk) begin
    if (stage_we && !stage_off[0]) begin
      stage_ff[stage_off[7:1]][15:8] <= req_data;
    end else if (stage_we) begin
      stage_ff[stage_off[7:1]][7:0] <= req_data;
    end
  end

  // ----------------------------------------
  // table write path
  // ----------------------------------------
  // word index is the zero-based address itself
  wire        tbl_we   = st_write && exc_ff == `MPR_EXC_NONE;
  wire [7:0]  tbl_idx  = start_addr[7:0] + wr_idx_ff;
  wire [15:0] tbl_data = (fc == `MPR_FC_WR_ONE) ? {hdr_ff[3], hdr_ff[4]} :
                         stage_ff[wr_idx_ff[6:0]];
  wire        wr_done  = fc != `MPR_FC_WR_MANY || wr_idx_ff == qty[7:0] - 8'h01;

  mpr_word_table #(
    .AW (`MPR_WORD_AW)
  ) u_table (
    .clk     (clk),
    .rst_b   (rst_b),
    .we      (tbl_we),
    .wr_idx  (tbl_idx),
    .wr_data (tbl_data),
    .rd_idx  (mw_rd_addr),
    .rd_data (mw_rd_data)
  );

  // ----------------------------------------
  // response byte selection
  // ----------------------------------------
  // echo replies reuse header bytes 0..4 unchanged
  wire [8:0] word_off = tx_idx_ff - `MPR_RD_HDR_LEN;
  assign in_reg_addr  = start_addr + {8'h00, word_off[8:1]};
  wire [7:0] rd_byte  = word_off[0] ? in_reg_data[7:0] : in_reg_data[15:8];
  wire [7:0] err_byte = (tx_idx_ff == 9'h000) ? fc + `MPR_FC_ERR_FLAG : exc_ff;
  wire [7:0] rd_hdr   = (tx_idx_ff == 9'h000) ? fc : {qty[6:0], 1'b0};
  wire [7:0] tx_byte  = (exc_ff != `MPR_EXC_NONE) ? err_byte :
                        (fc != `MPR_FC_RD_IREG) ? hdr_ff[tx_idx_ff[2:0]] :
                        (tx_idx_ff < `MPR_RD_HDR_LEN) ? rd_hdr : rd_byte;

  wire rsp_free = !rsp_valid_ff || rsp_ready;
  wire tx_load  = st_send && rsp_free && tx_idx_ff != tx_len_ff;
  wire tx_end   = st_send && rsp_free && tx_idx_ff == tx_len_ff;

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  // one request held from first byte to last response byte
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      mpr_pkg::MPR_ST_RECV: begin
        if (req_fire && req_last) begin
          nxt_state = mpr_pkg::MPR_ST_CHECK;
        end
      end
      mpr_pkg::MPR_ST_CHECK: begin
        if (chk_exc == `MPR_EXC_NONE && is_write) begin
          nxt_state = mpr_pkg::MPR_ST_WRITE;
        end else begin
          nxt_state = mpr_pkg::MPR_ST_SEND;
        end
      end
      mpr_pkg::MPR_ST_WRITE: begin
        if (wr_done) begin
          nxt_state = mpr_pkg::MPR_ST_SEND;
        end
      end
      mpr_pkg::MPR_ST_SEND: begin
        if (tx_end) begin
          nxt_state = mpr_pkg::MPR_ST_RECV;
        end
      end
      default: nxt_state = mpr_pkg::MPR_ST_RECV;
    endcase
  end

  // state, verdict and counters
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_ff  <= mpr_pkg::MPR_ST_RECV;
      exc_ff    <= `MPR_EXC_NONE;
      tx_len_ff <= 9'h000;
      wr_idx_ff <= 8'h00;
      tx_idx_ff <= 9'h000;
    end else begin
      state_ff <= nxt_state;
      if (st_check) begin
        exc_ff    <= chk_exc;
        tx_len_ff <= chk_len;
        wr_idx_ff <= 8'h00;
        tx_idx_ff <= 9'h000;
      end else begin
        if (st_write) wr_idx_ff <= wr_idx_ff + 8'h01;
        if (tx_load)  tx_idx_ff <= tx_idx_ff + 9'h001;
      end
    end
  end

  // output byte register, bit 0 carries the lsb
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rsp_valid_ff <= 1'b0;
      rsp_last_ff  <= 1'b0;
      rsp_data_ff  <= 8'h00;
    end else if (tx_load) begin
      rsp_valid_ff <= 1'b1;
      rsp_data_ff  <= tx_byte;
      rsp_last_ff  <= tx_idx_ff == tx_len_ff - 9'h001;
    end else if (rsp_ready) begin
      rsp_valid_ff <= 1'b0;
      rsp_last_ff  <= 1'b0;
    end
  end

  assign req_ready = st_recv;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_data  = rsp_data_ff;
  assign rsp_last  = rsp_last_ff;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  rd_len_a: assert property (st_check && fc == `MPR_FC_RD_IREG && chk_exc == `MPR_EXC_NONE
    |=> tx_len_ff == `MPR_RD_HDR_LEN + {$past(qty[7:0]), 1'b0})
    else $error("read reply length not 2 plus twice count");
  rd_qty_a: assert property (st_check && fc == `MPR_FC_RD_IREG && len_hdr && rd_addr_ok
    && qty > `MPR_RD_QTY_MAX |=> exc_ff == `MPR_EXC_VAL)
    else $error("read count above limit accepted");
  no_write_a: assert property (tbl_we |-> word_en && !srv_fault && start_addr[15:8] == 8'h00)
    else $error("table written after failed check");
  wr_one_a: assert property (st_write && fc == `MPR_FC_WR_ONE
    |-> tbl_data == qty && tbl_idx == start_addr[7:0] ##1 st_send)
    else $error("single write wrong value or length");
  echo_a: assert property (tx_load && exc_ff == `MPR_EXC_NONE && fc != `MPR_FC_RD_IREG
    |=> rsp_data == hdr_ff[$past(tx_idx_ff[2:0])])
    else $error("write reply differs from request");
  func_err_a: assert property (st_check && !is_bit_rd && !is_write
    && fc != `MPR_FC_RD_IREG |=> exc_ff == `MPR_EXC_FUNC && tx_len_ff == `MPR_ERR_LEN)
    else $error("unknown function not answered with 01");
  bit_err_a: assert property (st_check && is_bit_rd
    |=> exc_ff != `MPR_EXC_NONE ##1 st_send)
    else $error("bit read not answered with error frame");
  addr_first_a: assert property (st_check && fc == `MPR_FC_WR_MANY
    && rx_cnt_ff >= `MPR_WRN_HDR_LEN && !wrn_addr_ok |=> exc_ff == `MPR_EXC_ADDR)
    else $error("address not checked first");
  one_req_a: assert property (req_valid && req_ready && req_last |=> !req_ready)
    else $error("request taken while busy");
  last_a: assert property (rsp_valid && rsp_last |-> tx_idx_ff == tx_len_ff)
    else $error("last flag before final byte");

  rd_ok_c:   cover property (st_check && fc == `MPR_FC_RD_IREG && chk_exc == `MPR_EXC_NONE);
  wrn_ok_c:  cover property (st_write && fc == `MPR_FC_WR_MANY && wr_done);
  exc_c:     cover property (st_check && chk_exc == `MPR_EXC_ADDR);
  stall_c:   cover property (rsp_valid && !rsp_ready ##1 rsp_valid && rsp_ready);

endmodule

// [core/mpr_word_table.sv]
// memory_word table: one write port, one combinational read port
`timescale 1ns/1ps
`include "mpr_consts.svh"

module mpr_word_table #(
  parameter int AW = 8
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          we,
  input  wire logic [AW-1:0] wr_idx,
  input  wire logic [15:0]   wr_data,
  input  wire logic [AW-1:0] rd_idx,
  output logic      [15:0]   rd_data
);

  logic [15:0] word_ff [0:(1<<AW)-1];

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // clear on reset, single word write per cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < (1<<AW); i++) begin
        word_ff[i] <= `MPR_WORD_RST;
      end
    end else if (we) begin
      word_ff[wr_idx] <= wr_data;
    end
  end

  // read port brought out on mw_rd_addr/mw_rd_data; the server logic never reads it
  assign rd_data = word_ff[rd_idx];

endmodule
